// ===== logic/timer_pwm_capture_unit.sv
// 16-bit timer with single and dual pwm, capture/compare and coherent count readback
// assumes a byte register port with one-cycle strobes and inputs synchronous to i_mclk
`default_nettype none
module timer_pwm_capture_unit #(
    parameter int DATA_W = 8,                      // register byte width
    parameter int ADDR_W = 4,                      // register address width
    parameter int CNT_W  = 16                      // counter width
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    // timer input / complement output pin
    input  wire logic              i_tin,
    output logic                   o_tin_out,
    output logic                   o_tin_oe_n,
    // timer output pin
    output logic                   o_tout,
    // timer event pulse toward the interrupt controller
    output logic                   o_tmr_event
);
    // control registers
    logic [DATA_W-1:0] ctl0_r, ctl0_nxt;           // timer_control_zero
    logic [DATA_W-1:0] ctl1_r, ctl1_nxt;           // timer_control_one
    logic [DATA_W-1:0] db_r, db_nxt;               // dead band delay
    logic [CNT_W-1:0]  reload_r, reload_nxt;       // reload / compare
    logic [CNT_W-1:0]  pwm_r, pwm_nxt;             // pwm value / capture value

    // engine state
    timer_pwm_capture_pkg::tmr_state_e state_r, state_nxt;
    logic [CNT_W-1:0]  count_r, count_nxt;         // live counter
    logic [DATA_W-1:0] hold_r, hold_nxt;           // low byte latched by high read
    logic              toggle_r, toggle_nxt;       // toggle-mode output level
    logic              event_r, event_nxt;         // one-cycle event
    logic              tin_d_r;                    // previous input level
    logic              tout_r, tout_nxt;           // registered output pin
    logic              comp_r, comp_nxt;           // registered complement pin
    logic [DATA_W-1:0] rdata_r, rdata_nxt;         // registered read data

    // decoded fields
    logic       enable;                            // timer enable bit
    logic       pol;                               // idle level / sense
    logic [2:0] presc_exp;                         // prescale exponent
    logic [3:0] mode;                              // full mode code
    logic [1:0] iss;                               // event source select
    logic       edge_fall;                         // capture on falling edge
    logic       capmode;                           // capture/compare selected
    logic       pwm_mode;                          // either pwm mode
    logic       dual;                              // dual pwm selected
    logic       cap_edge;                          // selected edge seen this cycle
    logic       at_reload;                         // counter matches reload
    logic       pwm_active;                        // pwm positive phase
    logic       tick;                              // prescaled count enable
    logic       db_pos;                            // dead band primary side
    logic       db_neg;                            // dead band complement side

    // field decode from the control registers
    always_comb begin
        enable    = ctl1_r[timer_pwm_capture_pkg::CTL1_ENABLE_BIT];
        pol       = ctl1_r[timer_pwm_capture_pkg::CTL1_POL_BIT];
        presc_exp = ctl1_r[timer_pwm_capture_pkg::CTL1_PRESC_HI:
                           timer_pwm_capture_pkg::CTL1_PRESC_LO];
        // mode code is the high bit of control zero over the field of control one
        mode      = {ctl0_r[timer_pwm_capture_pkg::CTL0_MODE_HIGH_BIT],
                     ctl1_r[timer_pwm_capture_pkg::CTL1_MODE_HI:
                            timer_pwm_capture_pkg::CTL1_MODE_LO]};
        iss       = ctl0_r[timer_pwm_capture_pkg::CTL0_ISS_HI:
                           timer_pwm_capture_pkg::CTL0_ISS_LO];
        edge_fall = ctl0_r[timer_pwm_capture_pkg::CTL0_EDGE_BIT];
        capmode   = (mode == timer_pwm_capture_pkg::MODE_CAPCMP);
        dual      = (mode == timer_pwm_capture_pkg::MODE_PWM_DUAL);
        pwm_mode  = dual || (mode == timer_pwm_capture_pkg::MODE_PWM_SINGLE);
        // edge picked by software; the input is a plain synchronous level
        cap_edge  = edge_fall ? (tin_d_r && !i_tin)
                              : (!tin_d_r && i_tin);
        // reload registers double as the compare value in capture mode
        at_reload = (count_r == reload_r);
        // positive phase covers counts 1..pwm, the rest up to reload is negative
        pwm_active = (count_r <= pwm_r);
    end

    // prescaler only runs while the engine counts, so a period is reload*2**exp clocks
    timer_prescaler #(
        .EXP_W (3)
    ) u_presc (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_en   (state_r == timer_pwm_capture_pkg::ST_RUN),
        .i_exp  (presc_exp),
        .o_tick (tick)
    );

    // dead band split of the pwm level for dual mode, gap in system clocks
    timer_dead_band #(
        .DLY_W (DATA_W)
    ) u_db (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_en    (dual && (state_r == timer_pwm_capture_pkg::ST_RUN)),
        .i_level (pwm_active),
        .i_delay (db_r),
        .o_pos   (db_pos),
        .o_neg   (db_neg)
    );

    // register writes, read side effects and the counting engine
    always_comb begin
        ctl0_nxt   = ctl0_r;
        ctl1_nxt   = ctl1_r;
        db_nxt     = db_r;
        reload_nxt = reload_r;
        pwm_nxt    = pwm_r;
        count_nxt  = count_r;
        hold_nxt   = hold_r;
        state_nxt  = state_r;
        toggle_nxt = toggle_r;
        event_nxt  = 1'b0;

        // software writes; the engine below overrides them in the same cycle,
        // which only matters if software breaks the disable-first convention
        if (i_wr) begin
            if (i_addr == timer_pwm_capture_pkg::ADDR_COUNT_HI) begin
                count_nxt[15:8] = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_COUNT_LO) begin
                count_nxt[7:0] = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_RELOAD_HI) begin
                reload_nxt[15:8] = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_RELOAD_LO) begin
                reload_nxt[7:0] = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_PWM_HI) begin
                pwm_nxt[15:8] = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_PWM_LO) begin
                pwm_nxt[7:0] = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_CTL0) begin
                ctl0_nxt = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_CTL1) begin
                ctl1_nxt = i_wdata;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_DEADBAND) begin
                db_nxt = i_wdata;
            end
        end

        // high byte read while running snapshots the low byte; nothing else moves
        if (i_rd && enable && (i_addr == timer_pwm_capture_pkg::ADDR_COUNT_HI)) begin
            hold_nxt = count_r[7:0];
        end

        case (state_r)
            timer_pwm_capture_pkg::ST_IDLE: begin
                // stopped: output rests at the programmed idle level
                toggle_nxt = pol;
                if (enable) begin
                    // capture mode holds off until the first selected edge
                    state_nxt = capmode ? timer_pwm_capture_pkg::ST_WAIT
                                        : timer_pwm_capture_pkg::ST_RUN;
                end
            end
            timer_pwm_capture_pkg::ST_WAIT: begin
                if (!enable) begin
                    state_nxt = timer_pwm_capture_pkg::ST_IDLE;
                end else if (cap_edge) begin
                    // starting edge opens counting and raises no event
                    state_nxt = timer_pwm_capture_pkg::ST_RUN;
                end
            end
            timer_pwm_capture_pkg::ST_RUN: begin
                if (!enable) begin
                    state_nxt = timer_pwm_capture_pkg::ST_IDLE;
                end else if (capmode && cap_edge) begin
                    // capture: value minus start gives elapsed ticks
                    pwm_nxt   = count_r;
                    count_nxt = timer_pwm_capture_pkg::CNT_RESTART;
                    event_nxt = (iss != timer_pwm_capture_pkg::ISS_RELOAD);
                end else if (tick) begin
                    if (at_reload) begin
                        // every pass after the first restarts at 0001
                        count_nxt  = timer_pwm_capture_pkg::CNT_RESTART;
                        toggle_nxt = !toggle_r;
                        event_nxt  = !capmode ||
                                     (iss != timer_pwm_capture_pkg::ISS_CAPTURE);
                    end else begin
                        // a start count above 0001 (up to reload) simply shortens the first pass
                        count_nxt = count_r + timer_pwm_capture_pkg::CNT_STEP;
                    end
                end
            end
            default: begin
                state_nxt = timer_pwm_capture_pkg::ST_IDLE;
            end
        endcase
    end

    // pin levels: pwm uses the phase, other modes the toggle flip-flop
    always_comb begin
        tout_nxt = toggle_r;
        comp_nxt = pol;
        if (state_r != timer_pwm_capture_pkg::ST_RUN) begin
            tout_nxt = pol;
        end else if (dual) begin
            // both pins sit at the idle level during the dead gap
            tout_nxt = db_pos ? !pol : pol;
            comp_nxt = db_neg ? !pol : pol;
        end else if (pwm_mode) begin
            // transition sense: positive phase drives the inverse of idle
            tout_nxt = pwm_active ? !pol : pol;
        end
    end

    // read data, one cycle after the strobe; unmapped addresses read zero
    always_comb begin
        rdata_nxt = timer_pwm_capture_pkg::RST_BYTE;
        if (i_rd) begin
            if (i_addr == timer_pwm_capture_pkg::ADDR_COUNT_HI) begin
                rdata_nxt = count_r[15:8];
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_COUNT_LO) begin
                // live value when stopped, snapshot when running
                rdata_nxt = enable ? hold_r : count_r[7:0];
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_RELOAD_HI) begin
                rdata_nxt = reload_r[15:8];
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_RELOAD_LO) begin
                rdata_nxt = reload_r[7:0];
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_PWM_HI) begin
                rdata_nxt = pwm_r[15:8];
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_PWM_LO) begin
                rdata_nxt = pwm_r[7:0];
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_CTL0) begin
                rdata_nxt = ctl0_r;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_CTL1) begin
                rdata_nxt = ctl1_r;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_DEADBAND) begin
                rdata_nxt = db_r;
            end else if (i_addr == timer_pwm_capture_pkg::ADDR_STATUS) begin
                // engine state in the low bits, pin levels above
                rdata_nxt = {3'h0, comp_r, tout_r, state_r};
            end
        end
    end

    // all registers of the block
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctl0_r   <= timer_pwm_capture_pkg::RST_BYTE;
            ctl1_r   <= timer_pwm_capture_pkg::RST_BYTE;
            db_r     <= timer_pwm_capture_pkg::RST_BYTE;
            reload_r <= timer_pwm_capture_pkg::RST_RELOAD;
            pwm_r    <= timer_pwm_capture_pkg::RST_PWM;
            count_r  <= timer_pwm_capture_pkg::RST_COUNT;
            hold_r   <= timer_pwm_capture_pkg::RST_BYTE;
            state_r  <= timer_pwm_capture_pkg::ST_IDLE;
            toggle_r <= 1'b0;
            event_r  <= 1'b0;
            tin_d_r  <= 1'b0;
            tout_r   <= 1'b0;
            comp_r   <= 1'b0;
            rdata_r  <= timer_pwm_capture_pkg::RST_BYTE;
        end else begin
            ctl0_r   <= ctl0_nxt;
            ctl1_r   <= ctl1_nxt;
            db_r     <= db_nxt;
            reload_r <= reload_nxt;
            pwm_r    <= pwm_nxt;
            count_r  <= count_nxt;
            hold_r   <= hold_nxt;
            state_r  <= state_nxt;
            toggle_r <= toggle_nxt;
            event_r  <= event_nxt;
            tin_d_r  <= i_tin;
            tout_r   <= tout_nxt;
            comp_r   <= comp_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // outputs; the input pin is driven only when dual mode claims it
    assign o_rdata     = rdata_r;
    assign o_tout      = tout_r;
    assign o_tin_out   = comp_r;
    assign o_tin_oe_n  = !dual;
    assign o_tmr_event = event_r;
endmodule
`default_nettype wire

// ===== logic/timer_pwm_capture_pkg.sv
// constants and types used by the timer; its prescaler and dead band generator use none of them
// assumes one clock domain and a byte-wide register port with a 4-bit address
`default_nettype none
package timer_pwm_capture_pkg;
    // register addresses on the byte port
    localparam logic [3:0] ADDR_COUNT_HI  = 4'h0;   // running count, high byte
    localparam logic [3:0] ADDR_COUNT_LO  = 4'h1;   // running count, low byte
    localparam logic [3:0] ADDR_RELOAD_HI = 4'h2;   // reload / compare, high byte
    localparam logic [3:0] ADDR_RELOAD_LO = 4'h3;   // reload / compare, low byte
    localparam logic [3:0] ADDR_PWM_HI    = 4'h4;   // pwm value / capture, high byte
    localparam logic [3:0] ADDR_PWM_LO    = 4'h5;   // pwm value / capture, low byte
    localparam logic [3:0] ADDR_CTL0      = 4'h6;   // timer_control_zero
    localparam logic [3:0] ADDR_CTL1      = 4'h7;   // timer_control_one
    localparam logic [3:0] ADDR_DEADBAND  = 4'h8;   // pwm control: dead band delay
    localparam logic [3:0] ADDR_STATUS    = 4'h9;   // read-only engine state

    // timer_control_one fields
    localparam int CTL1_ENABLE_BIT   = 7;           // timer enable
    localparam int CTL1_POL_BIT      = 6;           // idle level / transition sense
    localparam int CTL1_PRESC_HI     = 5;           // prescale exponent, top bit
    localparam int CTL1_PRESC_LO     = 3;           // prescale exponent, low bit
    localparam int CTL1_MODE_HI      = 2;           // timer_mode_field, top bit
    localparam int CTL1_MODE_LO      = 0;           // timer_mode_field, low bit

    // timer_control_zero fields
    localparam int CTL0_MODE_HIGH_BIT = 7;          // timer_mode_high_bit
    localparam int CTL0_ISS_HI        = 6;          // timer_interrupt_source_select
    localparam int CTL0_ISS_LO        = 5;
    localparam int CTL0_EDGE_BIT      = 4;          // capture edge: 0 rising, 1 falling

    // full mode code {timer_mode_high_bit, timer_mode_field}
    localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
    localparam logic [3:0] MODE_CAPCMP     = 4'h7;
    localparam logic [3:0] MODE_PWM_DUAL   = 4'h8;

    // interrupt source select codes
    localparam logic [1:0] ISS_BOTH        = 2'h0;
    localparam logic [1:0] ISS_CAPTURE     = 2'h1;
    localparam logic [1:0] ISS_RELOAD      = 2'h2;

    // reset values and restart count
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_COUNT      = 16'h0001;
    localparam logic [15:0] RST_RELOAD     = 16'hFFFF;
    localparam logic [15:0] RST_PWM        = 16'h0000;
    localparam logic [15:0] CNT_RESTART    = 16'h0001;
    localparam logic [15:0] CNT_STEP       = 16'h0001;

    // engine states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } tmr_state_e;
endpackage
`default_nettype wire

// ===== logic/timer_prescaler.sv
// power-of-two prescaler producing a one-cycle tick enable
// assumes the exponent is stable while running; clears whenever not enabled
`default_nettype none
module timer_prescaler #(
    parameter int EXP_W = 3                        // exponent width
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // control
    input  wire logic             i_en,
    input  wire logic [EXP_W-1:0] i_exp,
    // tick out
    output logic                  o_tick
);
    localparam int CNT_W = (1 << EXP_W) - 1;       // counter width for largest divide
    localparam logic [CNT_W-1:0] ALL_ONES = {CNT_W{1'b1}};
    localparam logic [EXP_W-1:0] EXP_MAX  = {EXP_W{1'b1}};

    logic [CNT_W-1:0] cnt_r;                       // free count while enabled
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] mask;                        // low bits that must all be set

    // divide by 2**exp: tick when the masked low bits are all ones
    always_comb begin
        mask    = ALL_ONES >> (EXP_MAX - i_exp);
        o_tick  = i_en && ((cnt_r & mask) == mask);
        cnt_nxt = i_en ? cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} : '0;
    end

    // counter register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== logic/timer_dead_band.sv
// splits one pwm level into a pair of complementary levels with a dead gap
// assumes the gap is shorter than either phase; otherwise a phase can vanish
`default_nettype none
module timer_dead_band #(
    parameter int DLY_W = 8                        // dead band counter width
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // control
    input  wire logic             i_en,
    input  wire logic             i_level,
    input  wire logic [DLY_W-1:0] i_delay,         // gap in system clocks
    // paired outputs, high means asserted
    output logic                  o_pos,
    output logic                  o_neg
);
    logic             prev_r, prev_nxt;            // level last seen
    logic [DLY_W-1:0] cnt_r, cnt_nxt;              // remaining gap
    logic             pos_r, pos_nxt;
    logic             neg_r, neg_nxt;

    // on a level change drop both sides and wait the gap, or switch sides at once when the gap is zero
    always_comb begin
        prev_nxt = i_level;
        cnt_nxt  = cnt_r;
        pos_nxt  = pos_r;
        neg_nxt  = neg_r;
        if (!i_en) begin
            // both sides rest while the timer is stopped
            cnt_nxt = '0;
            pos_nxt = 1'b0;
            neg_nxt = 1'b0;
        end else if (i_level != prev_r) begin
            if (i_delay == '0) begin
                pos_nxt = i_level;
                neg_nxt = !i_level;
            end else begin
                pos_nxt = 1'b0;
                neg_nxt = 1'b0;
                cnt_nxt = i_delay;
            end
        end else if (cnt_r > {{(DLY_W-1){1'b0}}, 1'b1}) begin
            cnt_nxt = cnt_r - {{(DLY_W-1){1'b0}}, 1'b1};
        end else begin
            // gap over (or none pending): drive the side that matches the level
            cnt_nxt = '0;
            pos_nxt = prev_r;
            neg_nxt = !prev_r;
        end
    end

    // state registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            prev_r <= 1'b0;
            cnt_r  <= '0;
            pos_r  <= 1'b0;
            neg_r  <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            cnt_r  <= cnt_nxt;
            pos_r  <= pos_nxt;
            neg_r  <= neg_nxt;
        end
    end

    assign o_pos = pos_r;
    assign o_neg = neg_r;
endmodule
`default_nettype wire

// ===== dv/timer_pwm_capture_unit_properties.sv
// checker: pin and readback behaviour of the timer, judged at its ports
// assumes one clock; config bytes are shadowed from writes, not peeked
`default_nettype none
module tpcu_props (
    input wire logic       i_mclk, i_rst, i_wr, i_rd, i_tin,  // clock, strobes, pin
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata, o_rdata,
    input wire logic       o_tin_out, o_tin_oe_n, o_tout, o_tmr_event  // outputs
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctl0_r, ctl1_r, rld_r, db_r;          // shadows of written bytes
    wire  [3:0] mode = {ctl0_r[7], ctl1_r[2:0]};      // full mode code
    // count and pwm bytes move on their own, so only config is mirrored
    always_ff @(posedge i_mclk)
        if (i_rst) {ctl0_r, ctl1_r, rld_r, db_r} <= 32'h0000FF00;
        else if (i_wr)
            case (i_addr)
                4'h3: rld_r <= i_wdata;
                4'h6: ctl0_r <= i_wdata;
                4'h7: ctl1_r <= i_wdata;
                4'h8: db_r <= i_wdata;
                default: ;
            endcase
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata");
    oe_mode_a: assert property (o_tin_oe_n == (mode != 4'h8)) else $error("pin owner");
    no_overlap_a: assert property (
        mode == 4'h8 && ctl1_r[7] |-> o_tout == ctl1_r[6] || o_tin_out == ctl1_r[6])
        else $error("both sides on");
    idle_level_a: assert property (
        !ctl1_r[7] && $stable(ctl1_r) && ctl1_r == $past(ctl1_r, 2) |-> o_tout == ctl1_r[6])
        else $error("idle level");
    ctl_back_a: assert property (
        $past(i_rd && i_addr == 4'h7) |-> o_rdata == $past(ctl1_r)) else $error("ctl1");
    rld_back_a: assert property (
        $past(i_rd && i_addr == 4'h3) |-> o_rdata == $past(rld_r)) else $error("reload");
    db_back_a: assert property (
        $past(i_rd && i_addr == 4'h8) |-> o_rdata == $past(db_r)) else $error("dead band");
    tout_toggle_a: assert property (
        o_tmr_event && ctl1_r[7] && mode < 4'h3 |-> ##[0:1] o_tout != $past(o_tout))
        else $error("no toggle");
    ev_c: cover property (o_tmr_event);
    dual_c: cover property (!o_tin_oe_n && ctl1_r[7]);
    cap_c: cover property (o_tmr_event && mode == 4'h7);
endmodule
bind timer_pwm_capture_unit tpcu_props i_props (.i_mclk, .i_rst, .i_wr, .i_rd, .i_tin,
    .i_addr, .i_wdata, .o_rdata, .o_tin_out, .o_tin_oe_n, .o_tout, .o_tmr_event);
`default_nettype wire

// ===== dv/tin_src.sv
// partner: outside source on the shared timer input pin
// assumes the bench steers its level and muxes the wire
`default_nettype none
module tin_src (
    input  wire logic i_mclk,  // system clock
    input  wire logic i_want,  // level asked for
    output var  logic o_pin    // level on the pin, one cycle later
);
    timeunit 1ns;
    timeprecision 1ns;
    // registered so edges land on the clock like a synced input
    always @(posedge i_mclk) o_pin <= i_want;
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// bench: byte-port tasks and pin stimulus for the timer
// assumes the checker binds itself; 100 MHz clock
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0, want = 0;
    logic [3:0] i_addr = 4'h0, r;
    logic [7:0] i_wdata = 8'h00, rdata, hi, lo;
    logic [15:0] c1;
    wire tin, src, tio, oe_n, tout, ev;                   // pin wires
    int fail_count = 0, total_checks = 0, evn = 0, n;
    assign tin = (oe_n === 1'b0) ? tio : src;             // device owns pin in dual mode
    timer_pwm_capture_unit i_dut (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata(rdata), .i_tin(tin), .o_tin_out(tio), .o_tin_oe_n(oe_n), .o_tout(tout),
        .o_tmr_event(ev));
    tin_src i_src (.i_mclk, .i_want(want), .o_pin(src));
    initial forever #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) evn <= evn + int'(ev === 1'b1);   // event tally
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk) {i_addr, i_wdata, i_wr} <= {a, d, 1'h1};
        @(posedge i_mclk) i_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk) {i_addr, i_rd} <= {a, 1'h1};
        @(posedge i_mclk) i_rd <= 1'h0;
        #1 d = rdata;
    endtask
    // stop first, configure, enable last
    task automatic cfg(input logic [7:0] c0, c1, db, pw, rl);
        logic [39:0] a = 40'h7014582367;
        logic [7:0] v [10] = '{8'h00, 8'h00, 8'h01, 8'h00, pw, db, 8'h00, rl, c0, c1};
        for (int i = 9; i >= 0; i--) wr(a[4*i+:4], v[9-i]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'h0;
        rd(4'h3, lo);
        chk("reload lo", lo, 8'hFF);
        rd(4'hA, lo);
        chk("unmapped", lo, 8'h00);
        // free-running toggle: held low byte keeps the pair coherent
        for (int p = 0; p < 3; p += 2) begin
            cfg(8'h00, 8'h80 | 8'(p << 3), 8'h00, 8'h10, 8'h20);
            rd(4'h0, hi);
            repeat (4) @(posedge i_mclk);
            rd(4'h1, lo);
            c1 = {hi, lo};
            chk("held lo", c1, 16'h0001);
            rd(4'h0, hi);
            rd(4'h1, lo);
            chk("count step", {hi, lo} - c1, 16'(8 >> p));
            repeat (300) @(posedge i_mclk);
        end
        wr(4'h7, 8'h00);
        wr(4'h1, 8'h5A);
        rd(4'h1, lo);
        chk("live lo", lo, 8'h5A);
        wr(4'h7, 8'h40);
        repeat (2) @(posedge i_mclk) #1;
        chk("idle high", tout, 16'h0001);
        // single then dual pwm; gap 2 below both phases, reload above pwm
        for (int m = 0; m < 2; m++) begin
            cfg(8'(m << 7), m ? 8'h80 : 8'h83, 8'h02, 8'h04, 8'h0A);
            chk("pin owner", oe_n, 16'(m == 0));
            repeat (40) @(posedge i_mclk);
            for (n = 0; tout !== 1'b0 && n < 40; n++) @(posedge i_mclk) #1;
            for (n = 0; tout !== 1'b1 && n < 40; n++) @(posedge i_mclk) #1;
            for (n = 0; tout === 1'b1 && n < 40; n++) @(posedge i_mclk) #1;
            chk("high width", n, 16'(4 - 2 * m));
            for (n = 0; tio !== 1'b1 && n < 40; n++) @(posedge i_mclk) #1;
            for (n = 0; tio === 1'b1 && n < 40; n++) @(posedge i_mclk) #1;
            chk("comp width", n, 16'(4 * m));
        end
        rd(4'h8, lo);
        chk("dead band", lo, 8'h02);
        // rows {edge, source select, events}: start edge silent, then capture
        for (int k = 0; k < 3; k++) begin
            r = 4'(12'h4B1 >> (4 * k));
            want <= r[3];
            cfg({1'h0, r[2:1], r[3], 4'h0}, 8'h87, 8'h00, 8'h00, 8'hFF);
            n = evn;
            for (int e = 0; e < 3; e++) begin
                want <= r[3] ^ !e[0];
                repeat (8) @(posedge i_mclk);
            end
            chk("capture events", evn - n, 16'(r[0]));
        end
        report_and_stop();
    end
    initial begin
        #300000;
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
